/* rtl/ite_engine.sv */
// Interrupt-activated data mover: descriptor fetch, unit move, writeback
// Function
// R01: Vector, read descriptor, move data, write back
// R02: Descriptor state lives only in memory
// R03: Mode field: normal, repeat, block; 11 unused
// R04: Size field: byte, word, longword; 11 unused
// R05: Fixed source pointer, its writeback skipped
// R06: Source steps up or down by unit size
// R07: Short mode: 3-word descriptors, 24-bit pointers
// R08: Full mode: 4-word descriptors, 32-bit pointers
// R09: Odd address word/longword splits into pieces
// R10: Longword at 4n+2 splits into pieces
// R11: One activation may run chained descriptors
// R12: Chaining may require counter at zero
// R13: Pass activation to CPU as interrupt
// R14: Held descriptor may skip the fetch
// R15: Descriptor accesses are 32-bit single cycles
// R16: Software enables on-chip RAM before use
// R17: Interrupt every transfer or at count end
// R18: Area side picks repeat/block restore pointer
// R19: Chain condition; chained step clears nothing
// R20: Short pointers sign-extend from bit 23
// R21: Count decrements per unit; zero ends
`timescale 1ns/1ps
`default_nettype none
module ite_engine (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_full_addr,
  input wire logic i_skip_en,
  input wire logic i_act_valid,
  input wire logic [31:0] i_act_vector,
  output logic o_act_ready,
  output ite_pkg::ite_mem_req_t o_mem,
  input wire logic i_mem_ack,
  input wire logic [31:0] i_mem_rdata,
  output logic o_cpu_irq,
  output logic o_flag_clear,
  output logic o_busy
);
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] ext24(input logic [31:0] a, input logic full);
    return full ? a : {{8{a[23]}}, a[23:0]}; // R20
  endfunction

  function automatic logic [2:0] unit_bytes(input logic [1:0] sz);
    case (sz) // R04
      ite_pkg::SZ_WORD: return 3'h2;
      ite_pkg::SZ_LONG: return 3'h4;
      default: return 3'h1;
    endcase
  endfunction

  // Largest piece that is aligned and fits what is left
  function automatic logic [1:0] piece_size(input logic [1:0] a, input logic [2:0] rem);
    if (a[0] || rem == 3'h1) begin
      return ite_pkg::SZ_BYTE; // R09
    end else if (a[1] || rem < 3'h4) begin
      return ite_pkg::SZ_WORD; // R10
    end else begin
      return ite_pkg::SZ_LONG;
    end
  endfunction

  function automatic logic [31:0] step_addr(input logic [31:0] a, input logic [1:0] m,
                                            input logic [1:0] sz, input logic full);
    logic [31:0] d;
    d = {29'h0, unit_bytes(sz)};
    if (m == ite_pkg::STEP_INC) begin
      return ext24(a + d, full); // R06
    end else if (m == ite_pkg::STEP_DEC) begin
      return ext24(a - d, full); // R06
    end else begin
      return a; // R05
    end
  endfunction

  // Move the area pointer back by one repeat/block span
  function automatic logic [31:0] restore(input logic [31:0] a, input logic [1:0] m,
                                          input logic [1:0] sz, input logic [7:0] span,
                                          input logic full);
    logic [31:0] d;
    d = {24'h0, span} << {30'h0, sz};
    if (m == ite_pkg::STEP_INC) begin
      return ext24(a - d, full);
    end else if (m == ite_pkg::STEP_DEC) begin
      return ext24(a + d, full);
    end else begin
      return a;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  ite_pkg::ite_state_t state_r, state_nxt;
  // Descriptor image; no path to it but the memory bus
  logic [7:0] moda_r, moda_nxt, modb_r, modb_nxt; // R02
  logic [31:0] srcp_r, srcp_nxt, dstp_r, dstp_nxt; // R02
  logic [15:0] cnta_r, cnta_nxt, cntb_r, cntb_nxt; // R02
  logic [31:0] desc_r, desc_nxt, vec_r, vec_nxt, last_vec_r, last_vec_nxt;
  logic [31:0] acc_r, acc_nxt;
  logic [1:0] widx_r, widx_nxt;
  logic [2:0] k_r, k_nxt;
  logic held_r, held_nxt, fin_r, fin_nxt, irq_nxt, clr_nxt;

  logic [1:0] md, sz, sm, dm, psz, desc_last;
  logic chain_on, chain_at0, irq_all, area_src;
  logic [2:0] ub, pb;
  logic [31:0] pmask, desc_bytes;
  logic skip_hit, piece_last, wb_skip, chain;
  logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic [31:0] fifo_out_data;

  // Unit-end arithmetic
  logic [31:0] src_s, dst_s;
  logic [15:0] cnta_n, cntb_n;
  logic [7:0] cnta_lo;
  logic reload, fin_n;

  always_comb begin
    md = moda_r[ite_pkg::MA_MODE_LSB +: 2];
    sz = moda_r[ite_pkg::MA_SIZE_LSB +: 2];
    sm = moda_r[ite_pkg::MA_STEP_LSB +: 2];
    dm = modb_r[ite_pkg::MB_DST_STEP_LSB +: 2];
    chain_on = modb_r[ite_pkg::MB_CHAIN_EN_BIT];
    chain_at0 = modb_r[ite_pkg::MB_CHAIN_COND_BIT];
    irq_all = modb_r[ite_pkg::MB_IRQ_EVERY_BIT];
    area_src = modb_r[ite_pkg::MB_AREA_SIDE_BIT];
    desc_last = i_full_addr ? ite_pkg::DESC_LAST_FULL : ite_pkg::DESC_LAST_SHORT; // R07 R08
    desc_bytes = i_full_addr ? ite_pkg::DESC_BYTES_FULL : ite_pkg::DESC_BYTES_SHORT;
    ub = unit_bytes(sz);
    psz = piece_size(state_r == ite_pkg::ST_WR ? dstp_r[1:0] + k_r[1:0]
                                               : srcp_r[1:0] + k_r[1:0], ub - k_r);
    pb = unit_bytes(psz);
    pmask = (psz == ite_pkg::SZ_BYTE) ? 32'h000000ff :
            (psz == ite_pkg::SZ_WORD) ? 32'h0000ffff : 32'hffffffff;
    piece_last = (k_r + pb) == ub;
    skip_hit = i_skip_en && held_r && (i_act_vector == last_vec_r); // R14
    wb_skip = i_full_addr ?
      ((widx_r == ite_pkg::FULL_SRC_WORD && !sm[1]) ||
       (widx_r == ite_pkg::FULL_DST_WORD && !dm[1])) :
      ((widx_r == ite_pkg::SHORT_SRC_WORD && !sm[1]) ||
       (widx_r == ite_pkg::SHORT_DST_WORD && !dm[1])); // R05
    chain = chain_on && (!chain_at0 || fin_r); // R11 R12 R19
  end

  always_comb begin
    src_s = step_addr(srcp_r, sm, sz, i_full_addr); // R06
    dst_s = step_addr(dstp_r, dm, sz, i_full_addr);
    cnta_n = cnta_r;
    cntb_n = cntb_r;
    cnta_lo = cnta_r[7:0] - 8'h1;
    reload = 1'b0;
    fin_n = 1'b0;
    case (md) // R03
      ite_pkg::MODE_REPEAT: begin
        reload = cnta_lo == 8'h0;
        cnta_n = {cnta_r[15:8], reload ? cnta_r[15:8] : cnta_lo};
      end
      ite_pkg::MODE_BLOCK: begin
        reload = cnta_lo == 8'h0;
        cnta_n = {cnta_r[15:8], reload ? cnta_r[15:8] : cnta_lo};
        cntb_n = reload ? cntb_r - 16'h1 : cntb_r;
        fin_n = reload && cntb_n == 16'h0; // R21
      end
      default: begin
        cnta_n = cnta_r - 16'h1; // R21
        fin_n = cnta_n == 16'h0;
      end
    endcase
    if (reload && area_src) begin
      src_s = restore(src_s, sm, sz, cnta_r[15:8], i_full_addr); // R18
    end else if (reload) begin
      dst_s = restore(dst_s, dm, sz, cnta_r[15:8], i_full_addr); // R18
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_nxt = state_r;
    moda_nxt = moda_r;
    modb_nxt = modb_r;
    srcp_nxt = srcp_r;
    dstp_nxt = dstp_r;
    cnta_nxt = cnta_r;
    cntb_nxt = cntb_r;
    desc_nxt = desc_r;
    vec_nxt = vec_r;
    last_vec_nxt = last_vec_r;
    acc_nxt = acc_r;
    widx_nxt = widx_r;
    k_nxt = k_r;
    held_nxt = held_r;
    fin_nxt = fin_r;
    irq_nxt = 1'b0;
    clr_nxt = 1'b0;
    o_mem = '0;
    fifo_in_valid = 1'b0;
    fifo_out_ready = 1'b0;
    case (state_r)
      ite_pkg::ST_IDLE: begin
        if (i_act_valid) begin
          vec_nxt = i_act_vector;
          fin_nxt = 1'b0;
          k_nxt = 3'h0;
          acc_nxt = ite_pkg::REG_RESET;
          state_nxt = skip_hit ? ite_pkg::ST_RD : ite_pkg::ST_VEC; // R01 R14
        end
      end
      ite_pkg::ST_VEC: begin
        o_mem.req = 1'b1; // R01
        o_mem.size = ite_pkg::SZ_LONG;
        o_mem.addr = vec_r;
        if (i_mem_ack) begin
          desc_nxt = i_mem_rdata;
          widx_nxt = 2'h0;
          state_nxt = ite_pkg::ST_DRD;
        end
      end
      ite_pkg::ST_DRD: begin
        o_mem.req = 1'b1;
        o_mem.size = ite_pkg::SZ_LONG; // R15
        o_mem.addr = desc_r + {28'h0, widx_r, 2'h0};
        if (i_mem_ack) begin
          if (!i_full_addr) begin // R07
            case (widx_r)
              2'h0: begin
                moda_nxt = i_mem_rdata[31:24];
                srcp_nxt = ext24(i_mem_rdata, 1'b0); // R20
              end
              2'h1: begin
                modb_nxt = i_mem_rdata[31:24];
                dstp_nxt = ext24(i_mem_rdata, 1'b0);
              end
              default: begin
                cnta_nxt = i_mem_rdata[31:16];
                cntb_nxt = i_mem_rdata[15:0];
              end
            endcase
          end else begin // R08
            case (widx_r)
              2'h0: begin
                moda_nxt = i_mem_rdata[31:24];
                modb_nxt = i_mem_rdata[23:16];
              end
              2'h1: srcp_nxt = i_mem_rdata;
              2'h2: dstp_nxt = i_mem_rdata;
              default: begin
                cnta_nxt = i_mem_rdata[31:16];
                cntb_nxt = i_mem_rdata[15:0];
              end
            endcase
          end
          widx_nxt = widx_r + 2'h1;
          if (widx_r == desc_last) begin
            k_nxt = 3'h0;
            acc_nxt = ite_pkg::REG_RESET;
            state_nxt = ite_pkg::ST_RD;
          end
        end
      end
      ite_pkg::ST_RD: begin
        o_mem.req = 1'b1;
        o_mem.size = psz; // R09 R10
        o_mem.addr = srcp_r + {29'h0, k_r};
        if (i_mem_ack) begin
          acc_nxt = acc_r | ((i_mem_rdata & pmask) << {26'h0, k_r, 3'h0});
          k_nxt = k_r + pb;
          if (piece_last) begin
            state_nxt = ite_pkg::ST_PUSH;
          end
        end
      end
      ite_pkg::ST_PUSH: begin
        // Waits here while the FIFO is full
        fifo_in_valid = 1'b1;
        if (fifo_in_ready) begin
          k_nxt = 3'h0;
          state_nxt = ite_pkg::ST_WR;
        end
      end
      ite_pkg::ST_WR: begin
        o_mem.req = fifo_out_valid;
        o_mem.we = 1'b1;
        o_mem.size = psz; // R09 R10
        o_mem.addr = dstp_r + {29'h0, k_r};
        o_mem.wdata = fifo_out_data >> {26'h0, k_r, 3'h0};
        if (fifo_out_valid && i_mem_ack) begin
          k_nxt = k_r + pb;
          if (piece_last) begin
            fifo_out_ready = 1'b1;
            srcp_nxt = src_s;
            dstp_nxt = dst_s;
            cnta_nxt = cnta_n;
            cntb_nxt = cntb_n;
            fin_nxt = fin_n;
            k_nxt = 3'h0;
            acc_nxt = ite_pkg::REG_RESET;
            widx_nxt = 2'h0;
            // Block mode moves the whole block per activation
            state_nxt = (md == ite_pkg::MODE_BLOCK && !reload) ? ite_pkg::ST_RD
                                                                : ite_pkg::ST_WB;
          end
        end
      end
      ite_pkg::ST_WB: begin
        o_mem.req = !wb_skip; // R05
        o_mem.we = 1'b1;
        o_mem.size = ite_pkg::SZ_LONG; // R15
        o_mem.addr = desc_r + {28'h0, widx_r, 2'h0};
        if (!i_full_addr) begin
          o_mem.wdata = (widx_r == 2'h0) ? {moda_r, srcp_r[23:0]} :
                        (widx_r == 2'h1) ? {modb_r, dstp_r[23:0]} : {cnta_r, cntb_r};
        end else begin
          o_mem.wdata = (widx_r == 2'h0) ? {moda_r, modb_r, 16'h0} :
                        (widx_r == 2'h1) ? srcp_r :
                        (widx_r == 2'h2) ? dstp_r : {cnta_r, cntb_r};
        end
        if (wb_skip || i_mem_ack) begin
          widx_nxt = widx_r + 2'h1;
          if (widx_r == desc_last) begin
            widx_nxt = 2'h0;
            if (chain) begin
              desc_nxt = desc_r + desc_bytes; // R11
              held_nxt = 1'b0;
              fin_nxt = 1'b0;
              state_nxt = ite_pkg::ST_DRD;
            end else begin
              held_nxt = 1'b1;
              last_vec_nxt = vec_r;
              irq_nxt = irq_all || fin_r; // R13 R17
              clr_nxt = !(irq_all || fin_r);
              state_nxt = ite_pkg::ST_IDLE;
            end
          end
        end
      end
      default: state_nxt = ite_pkg::ST_IDLE;
    endcase
    o_act_ready = state_r == ite_pkg::ST_IDLE;
    o_busy = state_r != ite_pkg::ST_IDLE;
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      state_r <= ite_pkg::ST_IDLE;
      moda_r <= ite_pkg::REG_RESET[7:0];
      modb_r <= ite_pkg::REG_RESET[7:0];
      srcp_r <= ite_pkg::REG_RESET;
      dstp_r <= ite_pkg::REG_RESET;
      cnta_r <= ite_pkg::REG_RESET[15:0];
      cntb_r <= ite_pkg::REG_RESET[15:0];
      desc_r <= ite_pkg::REG_RESET;
      vec_r <= ite_pkg::REG_RESET;
      last_vec_r <= ite_pkg::REG_RESET;
      acc_r <= ite_pkg::REG_RESET;
      widx_r <= 2'h0;
      k_r <= 3'h0;
      held_r <= 1'b0;
      fin_r <= 1'b0;
      o_cpu_irq <= 1'b0;
      o_flag_clear <= 1'b0;
    end else begin
      state_r <= state_nxt;
      moda_r <= moda_nxt;
      modb_r <= modb_nxt;
      srcp_r <= srcp_nxt;
      dstp_r <= dstp_nxt;
      cnta_r <= cnta_nxt;
      cntb_r <= cntb_nxt;
      desc_r <= desc_nxt;
      vec_r <= vec_nxt;
      last_vec_r <= last_vec_nxt;
      acc_r <= acc_nxt;
      widx_r <= widx_nxt;
      k_r <= k_nxt;
      held_r <= held_nxt;
      fin_r <= fin_nxt;
      o_cpu_irq <= irq_nxt;
      o_flag_clear <= clr_nxt;
    end
  end

  ite_fifo #(
    .WIDTH(ite_pkg::FIFO_WIDTH),
    .DEPTH(ite_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_in_valid(fifo_in_valid),
    .o_in_ready(fifo_in_ready),
    .i_in_data(acc_r),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(fifo_out_ready),
    .o_out_data(fifo_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  sequence s_unit_end;
    state_r == ite_pkg::ST_WR && fifo_out_valid && i_mem_ack && piece_last;
  endsequence

  sequence s_wb_end;
    state_r == ite_pkg::ST_WB && (wb_skip || i_mem_ack) && widx_r == desc_last;
  endsequence

  a_fetch_vector: assert property ( // R01
    (state_r == ite_pkg::ST_IDLE && i_act_valid && !skip_hit)
    |=> (o_mem.req && !o_mem.we && o_mem.addr == $past(i_act_vector)))
    else $error("vector not read after activation");
  a_desc_long_access: assert property ( // R15
    (o_mem.req && (state_r == ite_pkg::ST_DRD || state_r == ite_pkg::ST_WB))
    |-> o_mem.size == ite_pkg::SZ_LONG)
    else $error("descriptor access not longword");
  a_piece_aligned: assert property ( // R09 R10
    o_mem.req |-> !(o_mem.size == ite_pkg::SZ_LONG && o_mem.addr[1:0] != 2'h0) &&
                  !(o_mem.size == ite_pkg::SZ_WORD && o_mem.addr[0]))
    else $error("misaligned bus piece");
  a_src_wb_skip: assert property ( // R05
    (state_r == ite_pkg::ST_WB && o_mem.req && !sm[1])
    |-> widx_r != (i_full_addr ? ite_pkg::FULL_SRC_WORD : ite_pkg::SHORT_SRC_WORD))
    else $error("fixed source pointer written back");
  a_src_inc_step: assert property ( // R06
    (s_unit_end and (md == ite_pkg::MODE_NORMAL && sm == ite_pkg::STEP_INC))
    |=> srcp_r[23:0] == $past(srcp_r[23:0]) + {21'h0, $past(ub)})
    else $error("source pointer did not step");
  a_count_dec: assert property ( // R21
    (s_unit_end and md == ite_pkg::MODE_NORMAL) |=> cnta_r == $past(cnta_r) - 16'h1)
    else $error("count not decremented");
  a_short_sext: assert property ( // R20
    (!i_full_addr && state_r == ite_pkg::ST_RD) |-> srcp_r[31:24] == {8{srcp_r[23]}})
    else $error("short pointer not sign-extended");
  a_irq_select: assert property ( // R17
    (s_wb_end and (!chain && (irq_all || fin_r))) |=> o_cpu_irq && !o_flag_clear)
    else $error("cpu interrupt not raised");
  a_chain_step: assert property ( // R19
    (s_wb_end and chain) |=> state_r == ite_pkg::ST_DRD ##1 (!o_cpu_irq && !o_flag_clear))
    else $error("chained step misbehaved");
endmodule // ite_engine
`default_nettype wire

/* rtl/ite_pkg.sv */
// Package of constants and carrier types for the interrupt transfer engine
package ite_pkg;

  // Transfer mode field codes
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_REPEAT = 2'h1;
  localparam logic [1:0] MODE_BLOCK = 2'h2;

  // Unit size field codes
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_LONG = 2'h2;

  // Address step mode codes (0x fixed)
  localparam logic [1:0] STEP_INC = 2'h2;
  localparam logic [1:0] STEP_DEC = 2'h3;

  // transfer_mode_a field positions
  localparam int MA_MODE_LSB = 6;
  localparam int MA_SIZE_LSB = 4;
  localparam int MA_STEP_LSB = 2;

  // transfer_mode_b field positions
  localparam int MB_CHAIN_EN_BIT = 7;
  localparam int MB_CHAIN_COND_BIT = 6;
  localparam int MB_IRQ_EVERY_BIT = 5;
  localparam int MB_AREA_SIDE_BIT = 4;
  localparam int MB_DST_STEP_LSB = 2;

  // Descriptor layout: last word index and length in bytes
  localparam logic [1:0] DESC_LAST_SHORT = 2'h2;
  localparam logic [1:0] DESC_LAST_FULL = 2'h3;
  localparam logic [31:0] DESC_BYTES_SHORT = 32'h0000000c;
  localparam logic [31:0] DESC_BYTES_FULL = 32'h00000010;

  // Word indices holding each pointer
  localparam logic [1:0] SHORT_SRC_WORD = 2'h0;
  localparam logic [1:0] SHORT_DST_WORD = 2'h1;
  localparam logic [1:0] FULL_SRC_WORD = 2'h1;
  localparam logic [1:0] FULL_DST_WORD = 2'h2;

  // Reset value of held descriptor state
  localparam logic [31:0] REG_RESET = 32'h00000000;

  // Data FIFO shape
  localparam int FIFO_WIDTH = 32;
  localparam int FIFO_DEPTH = 16;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_VEC = 3'b001,
    ST_DRD = 3'b010,
    ST_RD = 3'b011,
    ST_PUSH = 3'b100,
    ST_WR = 3'b101,
    ST_WB = 3'b110
  } ite_state_t;

  // Memory bus request, held until acknowledged
  typedef struct packed {
    logic req;
    logic we;
    logic [1:0] size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } ite_mem_req_t;

endpackage

/* rtl/ite_fifo.sv */
// Parameterised flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module ite_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wptr_r, wptr_nxt, rptr_r, rptr_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;

  always_comb begin
    o_in_ready = cnt_r != (AW+1)'(DEPTH);
    o_out_valid = cnt_r != '0;
    o_out_data = mem_r[rptr_r];
    push = i_in_valid && o_in_ready;
    pop = o_out_valid && i_out_ready;
    wptr_nxt = push ? wptr_r + AW'(1) : wptr_r;
    rptr_nxt = pop ? rptr_r + AW'(1) : rptr_r;
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      wptr_r <= '0;
      rptr_r <= '0;
      cnt_r <= '0;
    end else begin
      wptr_r <= wptr_nxt;
      rptr_r <= rptr_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Storage needs no reset; only the pointers and count define validity
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_r[wptr_r] <= i_in_data;
    end
  end
endmodule // ite_fifo
`default_nettype wire

/* testbench/ite_mem_model.sv */
// Behavioural memory slave for the transfer engine, adjustable latency
`timescale 1ns/1ps
`default_nettype none
module ite_mem_model (
  input wire logic i_clk,
  input wire logic i_ram_en,
  input wire logic i_slow,
  input wire ite_pkg::ite_mem_req_t i_mem,
  output logic o_ack,
  output logic [31:0] o_rdata
);
  logic [7:0] mem [0:255];
  logic [1:0] wait_r;
  logic [31:0] rd;
  int n;
  initial begin
    o_ack = 1'b0;
    o_rdata = 32'h0;
    wait_r = 2'h0;
  end
  always_comb begin
    rd = 32'h0;
    n = (i_mem.size == 2'h0) ? 1 : ((i_mem.size == 2'h1) ? 2 : 4);
    for (int k = 0; k < 4; k++) begin
      if (k < n) rd[8*k +: 8] = mem[i_mem.addr[7:0] + 8'(k)];
    end
  end
  always @(posedge i_clk) begin
    // Writes land only while the RAM is enabled
    if (o_ack && i_mem.req && i_mem.we && i_ram_en) begin
      for (int k = 0; k < n; k++) mem[i_mem.addr[7:0] + 8'(k)] <= i_mem.wdata[8*k +: 8];
    end
    if (i_mem.req && !o_ack && wait_r >= (i_slow ? 2'h2 : 2'h0)) begin
      o_ack <= 1'b1;
      o_rdata <= i_ram_en ? rd : ~o_rdata;
      wait_r <= 2'h0;
    end else begin
      o_ack <= 1'b0;
      // Released data toggles so a late sample never looks valid
      o_rdata <= ~o_rdata;
      wait_r <= (i_mem.req && !o_ack) ? wait_r + 2'h1 : 2'h0;
    end
  end
endmodule // ite_mem_model
`default_nettype wire

/* testbench/tb_top.sv */
// Self-checking bench for the interrupt transfer engine
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk, resetn, full_addr, skip_en, act_valid, act_ready, ram_en, slow;
  logic [31:0] act_vector;
  ite_pkg::ite_mem_req_t mem_req;
  logic mem_ack, cpu_irq, flag_clear, busy;
  logic [31:0] mem_rdata;
  logic [7:0] vec_addr;
  int fails, n_compared, vec_reads, misaligned, irqs, clears;

  ite_engine dut_u (.i_clk(clk), .i_resetn(resetn), .i_full_addr(full_addr),
    .i_skip_en(skip_en), .i_act_valid(act_valid), .i_act_vector(act_vector),
    .o_act_ready(act_ready), .o_mem(mem_req), .i_mem_ack(mem_ack),
    .i_mem_rdata(mem_rdata), .o_cpu_irq(cpu_irq), .o_flag_clear(flag_clear), .o_busy(busy));
  ite_mem_model mem_u (.i_clk(clk), .i_ram_en(ram_en), .i_slow(slow), .i_mem(mem_req),
    .o_ack(mem_ack), .o_rdata(mem_rdata));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (mem_req.req && mem_ack && !mem_req.we && mem_req.addr == {24'h0, vec_addr}) vec_reads++;
    if (mem_req.req && mem_ack && ((mem_req.size == 2'h1 && mem_req.addr[0]) ||
        (mem_req.size == 2'h2 && mem_req.addr[1:0] != 2'h0))) misaligned++;
    if (cpu_irq === 1'b1) irqs++;
    if (flag_clear === 1'b1) clears++;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic put32(input logic [7:0] a, input logic [31:0] v);
    for (int k = 0; k < 4; k++) mem_u.mem[a + 8'(k)] = v[8*k +: 8];
  endtask

  function automatic logic [31:0] get32(input logic [7:0] a);
    return {mem_u.mem[a + 8'h3], mem_u.mem[a + 8'h2], mem_u.mem[a + 8'h1], mem_u.mem[a]};
  endfunction

  // One activation; returns once idle again after its pulse was counted
  task automatic activate(input logic [7:0] vec);
    int t;
    irqs = 0;
    clears = 0;
    @(negedge clk);
    act_valid = 1'b1;
    act_vector = {24'h0, vec};
    @(negedge clk);
    act_valid = 1'b0;
    t = 0;
    while ((busy !== 1'b0 || irqs + clears == 0) && t < 400) begin
      @(negedge clk);
      t++;
    end
    @(negedge clk);
    check(32'(t < 400), 32'h1, "activation never finished");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_normal_byte();
    full_addr = 1'b0;
    skip_en = 1'b1;
    slow = 1'b0;
    put32(8'h00, 32'h00000020);
    put32(8'h20, 32'h08000040);
    put32(8'h24, 32'h00000060);
    put32(8'h28, 32'h00020000);
    put32(8'h40, 32'h0000b2a1);
    vec_addr = 8'h00;
    vec_reads = 0;
    activate(8'h00);
    check(32'(clears), 32'h1, "flag clear before count end");
    check(32'(irqs), 32'h0, "early interrupt");
    check(get32(8'h60), 32'h000000a1, "first byte");
    check(get32(8'h20), 32'h08000041, "source step");
    check(get32(8'h28), 32'h00010000, "count step");
    activate(8'h00);
    check(32'(irqs), 32'h1, "count end interrupt");
    check(get32(8'h60), 32'h000000b2, "second byte");
    check(get32(8'h28), 32'h00000000, "count zero");
    check(32'(vec_reads), 32'h1, "held descriptor reused");
    $display("test normal_byte done");
  endtask

  task automatic test_full_long();
    full_addr = 1'b1;
    skip_en = 1'b0;
    slow = 1'b1;
    put32(8'h04, 32'h00000080);
    put32(8'h80, 32'h2c280000);
    put32(8'h84, 32'h000000c1);
    put32(8'h88, 32'h000000d2);
    put32(8'h8c, 32'h00030000);
    put32(8'hc0, 32'h33221100);
    put32(8'hc4, 32'h00000044);
    misaligned = 0;
    activate(8'h04);
    check(32'(irqs), 32'h1, "interrupt every unit");
    check(get32(8'hd0), 32'h22110000, "low half of unit");
    check(get32(8'hd4), 32'h00004433, "high half of unit");
    check(32'(misaligned), 32'h0, "unaligned bus piece");
    check(get32(8'h84), 32'h000000bd, "source down by 4");
    check(get32(8'h88), 32'h000000d6, "destination up by 4");
    check(get32(8'h8c), 32'h00020000, "count step");
    $display("test full_long done");
  endtask

  task automatic test_chain_modes();
    full_addr = 1'b0;
    slow = 1'b0;
    put32(8'h08, 32'h000000a0);
    put32(8'ha0, 32'h88000040);
    put32(8'ha4, 32'hc8000070);
    put32(8'ha8, 32'h02020001);
    put32(8'hac, 32'h50000040);
    put32(8'hb0, 32'h00000072);
    put32(8'hb4, 32'h02020000);
    activate(8'h08);
    check(32'(irqs + clears), 32'h1, "one pulse per chain");
    check(get32(8'ha0), 32'h88000042, "block source advanced");
    check(get32(8'ha4), 32'hc8000070, "block area restored");
    check(32'(clears), 32'h1, "repeat never completes");
    check(get32(8'h70), 32'hb2a1b2a1, "block then word data");
    check(get32(8'ha8) & 32'h0000ffff, 32'h0, "block count");
    check(get32(8'hb4), 32'h02010000, "repeat counter");
    check(get32(8'hac), 32'h50000040, "fixed source");
    $display("test chain_modes done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    resetn = 1'b0;
    full_addr = 1'b0;
    skip_en = 1'b0;
    act_valid = 1'b0;
    act_vector = 32'h0;
    ram_en = 1'b0;
    slow = 1'b0;
    vec_addr = 8'h00;
    for (int k = 0; k < 256; k++) mem_u.mem[k] = 8'h00;
    repeat (4) @(negedge clk);
    check({28'h0, act_ready, busy, mem_req.req, cpu_irq | flag_clear}, 32'h8, "reset state");
    resetn = 1'b1;
    // Descriptors go to RAM only after it is switched on
    ram_en = 1'b1;
    test_normal_byte();
    test_full_long();
    test_chain_modes();
    tally_and_finish();
  end

  initial begin
    #50us;
    fails++;
    $display("[FAIL] t=%0t watchdog expired", $time);
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
